// *** or_move_consts.svh ***
`ifndef OR_MOVE_CONSTS_SVH
`define OR_MOVE_CONSTS_SVH
// Opcode fields of the three instructions handled here.
`define OP_OR_LIT       4'hd
`define OP_OR_LIT_MSB   11
`define OP_OR_LIT_LSB   8
`define OP_OR_FREG      6'h04
`define OP_MOVE_FREG    6'h08
`define OP_REG_MSB      11
`define OP_REG_LSB      6
`define DEST_BIT        5
`define FADDR_MSB       4
`define LIT_MSB         7
`define ACC_RESET       8'h00
`define ZERO_RESET      1'b0
`define EXEC_CYCLES     1
`endif

// *** or_move_pkg.sv ***
package or_move_pkg;
  // Decoded operation selected by the current instruction word.
  typedef enum logic [1:0] {
    OP_NONE,
    OP_OR_LIT,
    OP_OR_FREG,
    OP_MOVE_FREG
  } op_kind_t;

  // Request toward the register file, raised only by instructions that write back to a file register.
  typedef struct packed {
    logic       wr_en;
    logic [4:0] addr;
    logic [7:0] data;
  } freg_wr_t;

  // Instruction from the fetch stage.
  typedef struct packed {
    logic        valid;
    logic [11:0] word;
  } instr_t;
endpackage : or_move_pkg

// *** instr_decode.sv ***
`timescale 1ns/1ps
`include "or_move_consts.svh"
// Purely combinational decoder; shared by execute logic and its checks.
module instr_decode (
  // Instruction in
  input  wire logic [11:0]         word,
  // Decoded fields out
  output or_move_pkg::op_kind_t    kind,
  output logic                     dest_freg,
  output logic [4:0]               faddr,
  output logic [7:0]               literal
);
  // Match opcodes on their upper bits only; low bits are operands.
  always_comb begin
    kind = or_move_pkg::OP_NONE;
    if (word[`OP_OR_LIT_MSB:`OP_OR_LIT_LSB] == `OP_OR_LIT) begin
      kind = or_move_pkg::OP_OR_LIT;
    end else if (word[`OP_REG_MSB:`OP_REG_LSB] == `OP_OR_FREG) begin
      kind = or_move_pkg::OP_OR_FREG;
    end else if (word[`OP_REG_MSB:`OP_REG_LSB] == `OP_MOVE_FREG) begin
      kind = or_move_pkg::OP_MOVE_FREG;
    end
  end

  // Operand fields.
  assign dest_freg = word[`DEST_BIT];
  assign faddr     = word[`FADDR_MSB:0];
  assign literal   = word[`LIT_MSB:0];
endmodule : instr_decode

// *** or_and_move_instruction_exec.sv ***
`timescale 1ns/1ps
`include "or_move_consts.svh"
module or_and_move_instruction_exec (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  // Instruction from fetch stage
  input  wire or_move_pkg::instr_t  instr,
  // Register file read port
  output logic [4:0]                freg_rd_addr,
  input  wire logic [7:0]           freg_rd_data,
  // Register file write request
  output or_move_pkg::freg_wr_t     freg_wr,
  // Architectural state
  output logic [7:0]                acc,
  output logic                      zero_flag
);
  or_move_pkg::op_kind_t kind;
  logic                  dest_freg;
  logic [4:0]            faddr;
  logic [7:0]            literal;
  logic [7:0]            acc_reg;
  logic [7:0]            acc_next;
  logic                  zero_reg;
  logic                  zero_next;
  logic [7:0]            result;
  or_move_pkg::freg_wr_t wr_reg;
  or_move_pkg::freg_wr_t wr_next;

  instr_decode u_dec (
    .word      (instr.word),
    .kind      (kind),
    .dest_freg (dest_freg),
    .faddr     (faddr),
    .literal   (literal)
  );

  // The file register is read combinationally in the same cycle.
  assign freg_rd_addr = faddr;

  // Result and destination for each instruction, settled in one cycle.
  always_comb begin
    acc_next  = acc_reg;
    zero_next = zero_reg;
    wr_next   = '0;
    result    = 8'h00;
    if (instr.valid) begin
      case (kind)
        or_move_pkg::OP_OR_LIT: begin
          result    = acc_reg | literal;
          acc_next  = result;
          zero_next = (result == 8'h00);
        end
        or_move_pkg::OP_OR_FREG: begin
          result    = acc_reg | freg_rd_data;
          zero_next = (result == 8'h00);
          if (dest_freg) begin
            wr_next = '{wr_en: 1'b1, addr: faddr, data: result};
          end else begin
            acc_next = result;
          end
        end
        or_move_pkg::OP_MOVE_FREG: begin
          result    = freg_rd_data;
          // Zero updates even on a self-move so software can test a register.
          zero_next = (result == 8'h00);
          if (dest_freg) begin
            wr_next = '{wr_en: 1'b1, addr: faddr, data: result};
          end else begin
            acc_next = result;
          end
        end
        default: begin
          acc_next = acc_reg;
        end
      endcase
    end
  end

  // Registers only; the write request is registered so data leaves a flop.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acc_reg  <= `ACC_RESET;
      zero_reg <= `ZERO_RESET;
      wr_reg   <= '0;
    end else begin
      acc_reg  <= acc_next;
      zero_reg <= zero_next;
      wr_reg   <= wr_next;
    end
  end

  assign acc       = acc_reg;
  assign zero_flag = zero_reg;
  assign freg_wr   = wr_reg;

  // Checks.
  property p_or_lit;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_OR_LIT
      |=> acc == ($past(acc) | $past(literal));
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("literal OR wrong");

  property p_or_freg;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_OR_FREG && !dest_freg
      |=> acc == ($past(acc) | $past(freg_rd_data));
  endproperty
  a_or_freg: assert property (p_or_freg) else $error("register OR wrong");

  property p_dest_freg;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_OR_FREG && dest_freg
      |=> freg_wr.wr_en && freg_wr.addr == $past(faddr) && $stable(acc);
  endproperty
  a_dest_freg: assert property (p_dest_freg) else $error("OR dest wrong");

  property p_move_acc;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_MOVE_FREG && !dest_freg
      |=> acc == $past(freg_rd_data) && !freg_wr.wr_en;
  endproperty
  a_move_acc: assert property (p_move_acc) else $error("move to acc wrong");

  property p_move_self_zero;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_MOVE_FREG && dest_freg
      |=> zero_flag == ($past(freg_rd_data) == 8'h00) && $stable(acc);
  endproperty
  a_move_self_zero: assert property (p_move_self_zero) else $error("self move Z");

  property p_zero_match;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind != or_move_pkg::OP_NONE
      && !(kind == or_move_pkg::OP_MOVE_FREG || dest_freg && kind != or_move_pkg::OP_OR_LIT)
      |=> zero_flag == (acc == 8'h00);
  endproperty
  a_zero_match: assert property (p_zero_match) else $error("zero flag wrong");

  property p_idle_hold;
    @(posedge mclk) disable iff (!rst_n)
      !instr.valid |=> $stable(acc) && $stable(zero_flag) && !freg_wr.wr_en;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("state moved when idle");

  property p_wr_data;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_MOVE_FREG && dest_freg
      |=> freg_wr.data == $past(freg_rd_data);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("self move data wrong");

  // An OR that goes back to the register file still writes the ORed value.
  property p_or_wr_data;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_OR_FREG && dest_freg
      |=> freg_wr.data == ($past(acc) | $past(freg_rd_data));
  endproperty
  a_or_wr_data: assert property (p_or_wr_data) else $error("OR write data wrong");

  // Zero follows the result even when the accumulator is left alone.
  property p_or_wr_zero;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_OR_FREG && dest_freg
      |=> zero_flag == (($past(acc) | $past(freg_rd_data)) == 8'h00);
  endproperty
  a_or_wr_zero: assert property (p_or_wr_zero) else $error("OR write zero wrong");

  // Words that decode to none of the three leave every piece of state alone.
  property p_refused_hold;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid && kind == or_move_pkg::OP_NONE
      |=> $stable(acc) && $stable(zero_flag) && !freg_wr.wr_en;
  endproperty
  a_refused_hold: assert property (p_refused_hold) else $error("refused word moved state");

  // The read address must follow the current word, since the read is combinational.
  property p_rd_addr;
    @(posedge mclk) disable iff (!rst_n)
      instr.valid |-> freg_rd_addr == instr.word[4:0];
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");

  // A write-back pulse lasts one cycle unless another write-back follows it.
  property p_wr_pulse;
    @(posedge mclk) disable iff (!rst_n)
      freg_wr.wr_en && !(instr.valid && dest_freg && kind != or_move_pkg::OP_NONE
      && kind != or_move_pkg::OP_OR_LIT) |=> !freg_wr.wr_en;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");

  // Reset leaves the accumulator clear, zero low and no write pending.
  property p_reset_values;
    @(posedge mclk)
      !rst_n |=> acc == `ACC_RESET && zero_flag == `ZERO_RESET && !freg_wr.wr_en;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  // Scenario covers for the main paths.
  c_or_lit_zero: cover property (@(posedge mclk) disable iff (!rst_n)
    instr.valid && kind == or_move_pkg::OP_OR_LIT ##1 zero_flag);
  c_or_freg_wr: cover property (@(posedge mclk) disable iff (!rst_n)
    instr.valid && kind == or_move_pkg::OP_OR_FREG && dest_freg);
  c_move_self: cover property (@(posedge mclk) disable iff (!rst_n)
    instr.valid && kind == or_move_pkg::OP_MOVE_FREG && dest_freg ##1 zero_flag);
  c_or_freg_acc: cover property (@(posedge mclk) disable iff (!rst_n)
    instr.valid && kind == or_move_pkg::OP_OR_FREG && !dest_freg);
endmodule : or_and_move_instruction_exec

// *** reg_file_model.sv ***
`timescale 1ns/1ps
// Register file stand-in: reads are combinational, writes land on the edge.
module reg_file_model (
  // Clock
  input  wire logic                  mclk,
  // Read port
  input  wire logic [4:0]            rd_addr,
  output logic [7:0]                 rd_data,
  // Write request
  input  wire or_move_pkg::freg_wr_t wr
);
  logic [7:0] mem [32];
  // The core's write request is registered, so a write still waiting for its edge is forwarded.
  // Without this a back-to-back read of the same register would see stale data.
  assign rd_data = (wr.wr_en && wr.addr == rd_addr) ? wr.data : mem[rd_addr];
  // Plain always so the bench may preload the array.
  always @(posedge mclk) begin
    if (wr.wr_en) begin
      mem[wr.addr] <= wr.data;
    end
  end
endmodule : reg_file_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic                  mclk;
  logic                  rst_n;
  or_move_pkg::instr_t   instr;
  or_move_pkg::freg_wr_t freg_wr;
  logic [4:0]            rd_addr;
  logic [7:0]            rd_data;
  logic [7:0]            acc;
  logic                  zero_flag;
  logic [7:0]            sh [32];
  logic [7:0]            e_acc;
  logic                  e_z;
  logic [31:0]           seed;
  logic [31:0]           r;
  int                    fail_count;
  int                    check_count;

  or_and_move_instruction_exec or_and_move_instruction_exec_inst (
    .mclk(mclk), .rst_n(rst_n), .instr(instr), .freg_rd_addr(rd_addr),
    .freg_rd_data(rd_data), .freg_wr(freg_wr), .acc(acc), .zero_flag(zero_flag));
  reg_file_model reg_file_model_inst (
    .mclk(mclk), .rd_addr(rd_addr), .rd_data(rd_data), .wr(freg_wr));

  // Free-running core clock.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] xrand(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xrand

  task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One instruction per cycle; expectations come from the bench shadow state.
  task automatic step(input logic v, input logic [11:0] w);
    logic [7:0] res;
    logic       hit;
    logic       wr;
    hit = v;
    wr  = 1'b0;
    if (w[11:8] == 4'hd) res = e_acc | w[7:0];
    else if (w[11:6] == 6'h04) res = e_acc | sh[w[4:0]];
    else if (w[11:6] == 6'h08) res = sh[w[4:0]];
    else hit = 1'b0;
    if (hit) begin
      e_z = (res == 8'h00);
      wr  = w[5] && (w[11:8] != 4'hd);
      if (wr) sh[w[4:0]] = res;
      else e_acc = res;
    end
    instr = '{valid: v, word: w};
    @(posedge mclk);
    #5;
    check("acc", acc, e_acc);
    check("zero", zero_flag, e_z);
    check("wr_en", freg_wr.wr_en, wr);
    if (wr) check("wr", {freg_wr.addr, freg_wr.data}, {w[4:0], res});
  endtask : step

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // Hang guard: the run is far shorter than this.
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end

  // Reset, corner cases from the worked examples, then random traffic.
  initial begin
    rst_n = 1'b0;
    instr = '0;
    seed  = 32'h4f462f34;
    e_acc = 8'h00;
    e_z   = 1'b0;
    for (int i = 0; i < 32; i++) begin
      seed = xrand(seed);
      sh[i] = (i == 3) ? 8'h00 : seed[7:0];
      reg_file_model_inst.mem[i] = sh[i];
    end
    repeat (3) @(posedge mclk);
    #5;
    rst_n = 1'b1;
    check("rst", {acc, zero_flag, freg_wr.wr_en}, 13'h0);
    step(1'b1, 12'h203);
    step(1'b1, 12'h223);
    step(1'b1, 12'hd00);
    step(1'b1, 12'hd9a);
    step(1'b1, 12'hd35);
    step(1'b0, 12'hd01);
    step(1'b1, 12'h0ff);
    step(1'b1, 12'h123);
    $display("test corner done");
    repeat (500) begin
      seed = xrand(seed);
      r = seed;
      case (r[1:0])
        2'h0: step(r[31:29] != 3'h0, {4'hd, r[15:8]});
        2'h1: step(r[31:29] != 3'h0, {6'h04, r[13:8]});
        2'h2: step(r[31:29] != 3'h0, {6'h08, r[13:8]});
        default: step(r[31:29] != 3'h0, r[27:16]);
      endcase
    end
    $display("test random done");
    wrap_up();
  end
endmodule : testbench
